// [rtl/video_out_cfg.svh]
`ifndef VIDEO_OUT_CFG_SVH
`define VIDEO_OUT_CFG_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_STATE       8'h04
`define REG_IRQ_STATUS  8'h08
`define REG_IRQ_MASK    8'h0c

// Control register fields
`define CTRL_DRIVE_HI   0
`define CTRL_TWO_PIX    1
`define CTRL_STAGGER_N  2
`define CTRL_DRV_ON_N   3
`define CTRL_CHIP_ON_N  4
`define CTRL_AUTO_OFF   5
`define CTRL_W          6
`define CTRL_RESET      6'h1c

// State register fields
`define STATE_LINK      0
`define STATE_DRV_ON    1
`define STATE_TWO_PIX   2
`define STATE_TPIX_LSB  16

// Interrupt event bits
`define EVT_LINK_UP     0
`define EVT_LINK_DOWN   1
`define EVT_W           2

// Link activity timing, in pixel clock periods
`define IDLE_PERIODS    1000000
`define ACTIVE_WINDOW   1600

// AHB encodings
`define HSIZE_WORD      3'h2

`endif

// [rtl/video_out_pkg.sv]
package video_out_pkg;

	typedef logic [23:0] pixel_t;

	typedef enum logic {
		EVEN_IDLE  = 1'b0,
		EVEN_DELAY = 1'b1
	} even_state_t;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ps

module pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;

	// A bit takes its new value only once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r  <= '0;
		end else if (ce) begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
		end
	end

	assign q = q_r;

endmodule

// [rtl/link_detect.sv]
`timescale 1ns/1ps
`include "video_out_cfg.svh"

module link_detect #(
	parameter int unsigned IDLE_PERIODS = `IDLE_PERIODS
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic run,
	input  wire logic pix_tick,
	input  wire logic de_edge,
	output logic      active
);

	localparam logic [19:0] IDLE_LAST = 20'(IDLE_PERIODS - 1);
	localparam logic [10:0] WINDOW    = 11'(`ACTIVE_WINDOW);

	logic        active_r;
	logic        armed_r;
	logic [19:0] idle_cnt_r;
	logic [10:0] win_cnt_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			active_r   <= 1'b0;
			armed_r    <= 1'b0;
			idle_cnt_r <= '0;
			win_cnt_r  <= '0;
		end else if (ce && run && pix_tick) begin
			if (active_r) begin
				if (de_edge) begin
					idle_cnt_r <= '0;
				end else if (idle_cnt_r == IDLE_LAST) begin
					active_r   <= 1'b0;
					armed_r    <= 1'b0;
					idle_cnt_r <= '0;
				end else begin
					idle_cnt_r <= idle_cnt_r + 20'h1;
				end
			end else if (de_edge) begin
				if (armed_r && win_cnt_r < WINDOW) begin
					active_r   <= 1'b1;
					armed_r    <= 1'b0;
					idle_cnt_r <= '0;
				end else begin
					armed_r   <= 1'b1;
					win_cnt_r <= '0;
				end
			end else if (armed_r && win_cnt_r != WINDOW) begin
				win_cnt_r <= win_cnt_r + 11'h1;
			end
		end
	end

	assign active = active_r;

endmodule

// [rtl/video_out_ctrl.sv]
`timescale 1ns/1ps
`include "video_out_cfg.svh"

// Summary of operation
// - The drive strength output follows the drive strength select bit.
// - Staggering applies only in two-pixel mode; otherwise it is ignored.
// - Staggering delays the even pixel by a quarter output clock period.
// - In two-pixel mode the output clock period is two pixel periods.
// - Drivers-off floats all outputs but sync detect and control out 1.
// - Chip power-down stops the core and floats every output.
// - In chip power-down every input but the power-down and drive strength select bits is ignored.
// - Both power-down controls come out of reset in the normal state.
// - The link goes inactive after 1e6 pixel periods with no DE change.
// - While inactive, two DE changes within 1600 periods make it active.
module video_out_ctrl #(
	parameter int unsigned IDLE_PERIODS = `IDLE_PERIODS
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq,
	input  wire logic        pixel_clk_in,
	input  wire logic        de_in,
	input  wire logic        hsync_in,
	input  wire logic        vsync_in,
	input  wire logic        control_out_1_in,
	input  wire logic [23:0] pixel_in,
	output logic             drive_strength_hi,
	output logic             output_pixel_clock,
	output logic      [23:0] pixel_even_out,
	output logic      [23:0] pixel_odd_out,
	output logic             de_out,
	output logic             hsync_out,
	output logic             vsync_out,
	output logic             data_oe,
	output logic             control_out_1,
	output logic             control_out_1_oe,
	output logic             link_activity_detect,
	output logic             link_activity_detect_oe
);

	// Synchronised pins
	logic [28:0]                 pin_q;
	logic                        pclk_q;
	logic                        de_q;
	video_out_pkg::pixel_t       pix_q;

	// Registers
	logic [`CTRL_W-1:0]          ctrl_r;
	logic [`EVT_W-1:0]           status_r;
	logic [`EVT_W-1:0]           mask_r;
	logic                        irq_r;

	// Bus
	logic                        accept;
	logic                        wr_pend_r;
	logic                        rd_pend_r;
	logic [7:0]                  addr_r;
	logic [31:0]                 hrdata_r;
	logic                        hreadyout_r;
	logic                        hresp_r;
	logic                        wr_ctrl;
	logic                        wr_status;
	logic                        wr_mask;

	// Pixel path
	logic                        run;
	logic                        two_pix;
	logic                        stagger_on;
	logic                        pclk_prev_r;
	logic                        de_prev_r;
	logic                        pix_tick;
	logic                        de_edge;
	logic                        cur_odd;
	logic                        phase_r;
	logic [15:0]                 per_cnt_r;
	logic [15:0]                 tpix_r;
	logic [14:0]                 delay_cnt_r;
	video_out_pkg::even_state_t  even_state_r;
	video_out_pkg::pixel_t       even_hold_r;
	video_out_pkg::pixel_t       even_pend_r;
	video_out_pkg::pixel_t       pixel_even_r;
	video_out_pkg::pixel_t       pixel_odd_r;
	logic                        de_out_r;
	logic                        hsync_r;
	logic                        vsync_r;
	logic                        control_out_1_r;
	logic                        output_pixel_clock_r;

	// Output drive and link state
	logic                        drv_on;
	logic                        drive_r;
	logic                        data_oe_r;
	logic                        control_out_1_oe_r;
	logic                        link_oe_r;
	logic                        link_active;
	logic                        link_prev_r;
	logic [`EVT_W-1:0]           evt;

	pin_sync #(
		.W(29)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst    (rst),
		.ce     (ce),
		.d      ({pixel_in, control_out_1_in, vsync_in, hsync_in, de_in,
		          pixel_clk_in}),
		.q      (pin_q)
	);

	assign pclk_q = pin_q[0];
	assign de_q   = pin_q[1];
	assign pix_q  = pin_q[28:5];

	// core runs only while chip is on
	assign run        = ctrl_r[`CTRL_CHIP_ON_N];
	assign two_pix    = ctrl_r[`CTRL_TWO_PIX];
	assign stagger_on = two_pix & ~ctrl_r[`CTRL_STAGGER_N];
	assign pix_tick   = pclk_q & ~pclk_prev_r;
	assign de_edge    = pix_tick & (de_q ^ de_prev_r);
	// Rising DE realigns so the first active pixel is even
	assign cur_odd    = phase_r & ~(de_q & ~de_prev_r);

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			`REG_CTRL:       v[`CTRL_W-1:0] = ctrl_r;
			`REG_STATE: begin
				v[`STATE_LINK]    = link_active;
				v[`STATE_DRV_ON]  = drv_on;
				v[`STATE_TWO_PIX] = two_pix;
				v[`STATE_TPIX_LSB +: 16] = tpix_r;
			end
			`REG_IRQ_STATUS: v[`EVT_W-1:0] = status_r;
			`REG_IRQ_MASK:   v[`EVT_W-1:0] = mask_r;
			default:         v = '0;
		endcase
		return v;
	endfunction

	// AHB-Lite slave: writes take no wait state, reads take one
	assign accept    = hsel & htrans[1] & hready;
	assign wr_ctrl   = wr_pend_r & (addr_r == `REG_CTRL);
	assign wr_status = wr_pend_r & (addr_r == `REG_IRQ_STATUS);
	assign wr_mask   = wr_pend_r & (addr_r == `REG_IRQ_MASK);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			addr_r      <= '0;
			hrdata_r    <= '0;
			hreadyout_r <= 1'b1;
		end else if (ce) begin
			wr_pend_r <= accept & hwrite & (hsize == `HSIZE_WORD);
			if (accept) begin
				addr_r <= haddr[7:0];
			end
			if (accept && !hwrite) begin
				rd_pend_r   <= 1'b1;
				hreadyout_r <= 1'b0;
			end else if (rd_pend_r) begin
				rd_pend_r   <= 1'b0;
				hrdata_r    <= reg_read(addr_r);
				hreadyout_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hresp_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_r <= `CTRL_RESET;
			mask_r <= '0;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl_r <= hwdata[`CTRL_W-1:0];
			end
			if (wr_mask) begin
				mask_r <= hwdata[`EVT_W-1:0];
			end
		end
	end

	// Events beat a write-one clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_r <= '0;
			irq_r    <= 1'b0;
		end else if (ce) begin
			status_r <= (status_r & ~({`EVT_W{wr_status}} &
			            hwdata[`EVT_W-1:0])) | evt;
			irq_r    <= |(status_r & mask_r);
		end
	end

	link_detect #(
		.IDLE_PERIODS(IDLE_PERIODS)
	) u_link_detect (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.run     (run),
		.pix_tick(pix_tick),
		.de_edge (de_edge),
		.active  (link_active)
	);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			link_prev_r <= 1'b0;
		end else if (ce) begin
			link_prev_r <= link_active;
		end
	end

	assign evt[`EVT_LINK_UP]   = link_active & ~link_prev_r;
	assign evt[`EVT_LINK_DOWN] = ~link_active & link_prev_r;

	// Pixel period in reference clocks, for the stagger delay
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pclk_prev_r <= 1'b0;
			per_cnt_r   <= '0;
			tpix_r      <= '0;
		end else if (ce && run) begin
			pclk_prev_r <= pclk_q;
			if (pix_tick) begin
				per_cnt_r <= '0;
				tpix_r    <= (per_cnt_r == 16'hffff) ? per_cnt_r :
				             per_cnt_r + 16'h1;
			end else if (per_cnt_r != 16'hffff) begin
				per_cnt_r <= per_cnt_r + 16'h1;
			end
		end
	end

	// Pixel pairing and even-pixel stagger
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			de_prev_r    <= 1'b0;
			phase_r      <= 1'b0;
			even_hold_r  <= '0;
			even_pend_r  <= '0;
			pixel_even_r <= '0;
			pixel_odd_r  <= '0;
			de_out_r     <= 1'b0;
			hsync_r      <= 1'b0;
			vsync_r      <= 1'b0;
			control_out_1_r       <= 1'b0;
			delay_cnt_r  <= '0;
			even_state_r <= video_out_pkg::EVEN_IDLE;
		end else if (ce && run) begin
			if (pix_tick) begin
				de_prev_r <= de_q;
				if (!two_pix) begin
					phase_r      <= 1'b0;
					pixel_even_r <= pix_q;
					pixel_odd_r  <= '0;
					de_out_r     <= de_q;
					hsync_r      <= pin_q[2];
					vsync_r      <= pin_q[3];
					control_out_1_r       <= pin_q[4];
				end else if (!cur_odd) begin
					phase_r     <= 1'b1;
					even_hold_r <= pix_q;
				end else begin
					phase_r     <= 1'b0;
					pixel_odd_r <= pix_q;
					de_out_r    <= de_q;
					hsync_r     <= pin_q[2];
					vsync_r     <= pin_q[3];
					control_out_1_r      <= pin_q[4];
					if (stagger_on) begin
						even_pend_r  <= even_hold_r;
						delay_cnt_r  <= tpix_r[15:1];
						even_state_r <= video_out_pkg::EVEN_DELAY;
					end else begin
						pixel_even_r <= even_hold_r;
					end
				end
			end else if (even_state_r == video_out_pkg::EVEN_DELAY) begin
				if (delay_cnt_r <= 15'h1) begin
					pixel_even_r <= even_pend_r;
					even_state_r <= video_out_pkg::EVEN_IDLE;
				end else begin
					delay_cnt_r <= delay_cnt_r - 15'h1;
				end
			end
		end
	end

	// output clock toggles once per pixel in two-pixel mode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			output_pixel_clock_r <= 1'b0;
		end else if (ce && run) begin
			if (!two_pix) begin
				output_pixel_clock_r <= ~pclk_q;
			end else if (pix_tick) begin
				output_pixel_clock_r <= ~cur_odd;
			end
		end
	end

	// optional automatic drivers-off on link loss
	assign drv_on = run & ctrl_r[`CTRL_DRV_ON_N] &
	                (~ctrl_r[`CTRL_AUTO_OFF] | link_active);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drive_r   <= 1'b0;
			data_oe_r <= 1'b0;
			control_out_1_oe_r <= 1'b0;
			link_oe_r <= 1'b0;
		end else if (ce) begin
			drive_r   <= ctrl_r[`CTRL_DRIVE_HI];
			data_oe_r <= drv_on;
			control_out_1_oe_r <= run;
			link_oe_r <= run;
		end
	end

	assign hrdata                  = hrdata_r;
	assign hreadyout               = hreadyout_r;
	assign hresp                   = hresp_r;
	assign irq                     = irq_r;
	assign drive_strength_hi       = drive_r;
	assign output_pixel_clock      = output_pixel_clock_r;
	assign pixel_even_out          = pixel_even_r;
	assign pixel_odd_out           = pixel_odd_r;
	assign de_out                  = de_out_r;
	assign hsync_out               = hsync_r;
	assign vsync_out               = vsync_r;
	assign data_oe                 = data_oe_r;
	assign control_out_1           = control_out_1_r;
	assign control_out_1_oe        = control_out_1_oe_r;
	assign link_activity_detect    = link_active;
	assign link_activity_detect_oe = link_oe_r;

endmodule

// [sim/rx_output_power_sync_ctrl_props.sv]
`timescale 1ns/1ps
module rx_output_props #(
	parameter int unsigned IDLE_PERIODS = 40
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        drive_strength_hi,
	input wire logic        output_pixel_clock,
	input wire logic [23:0] pixel_even_out,
	input wire logic        data_oe,
	input wire logic        control_out_1_oe,
	input wire logic        link_activity_detect,
	input wire logic        link_activity_detect_oe
);
	logic       pend_r;
	logic       rst_q_r;
	logic [5:0] ctrl_r;
	default clocking cb @(posedge ref_clk); endclocking
	// Outputs still show reset values one edge after release
	default disable iff (rst || rst_q_r);
	// Shadow of the control word, tracked from the bus
	always_ff @(posedge ref_clk) begin
		rst_q_r <= rst;
		if (rst) begin
			pend_r <= 1'b0;
			ctrl_r <= 6'h1c;
		end else begin
			if (pend_r)
				ctrl_r <= hwdata[5:0];
			pend_r <= hsel && htrans[1] && hready && hwrite &&
				hsize == 3'h2 && haddr[7:0] == 8'h00;
		end
	end
	a_oe_pair_match: assert property (
		control_out_1_oe == link_activity_detect_oe) else $error("oe split");
	a_float_all_off: assert property (
		!control_out_1_oe |-> !data_oe) else $error("data driven in off");
	a_sync_frozen: assert property (
		!control_out_1_oe && !$past(control_out_1_oe) && !ctrl_r[4]
		|-> $stable(link_activity_detect)) else $error("sync moved in off");
	a_pixels_frozen: assert property (
		!control_out_1_oe && !$past(control_out_1_oe) && !ctrl_r[4]
		|-> $stable(pixel_even_out) && $stable(output_pixel_clock))
		else $error("pixel path moved in off");
	a_drive_follow: assert property (
		($stable(ctrl_r) && ctrl_r[4])[*2] |-> drive_strength_hi == ctrl_r[0])
		else $error("drive strength wrong");
	a_drivers_off: assert property (
		$stable(ctrl_r)[*2] ##0 ctrl_r[4:3] == 2'b10
		|-> !data_oe && control_out_1_oe) else $error("drivers off wrong");
	a_chip_off: assert property (
		$stable(ctrl_r)[*2] ##0 !ctrl_r[4]
		|-> !data_oe && !control_out_1_oe) else $error("chip off wrong");
	a_normal_on: assert property (
		$stable(ctrl_r)[*2] ##0 ctrl_r[5:3] == 3'b011
		|-> data_oe && control_out_1_oe) else $error("normal not driving");
endmodule

bind video_out_ctrl rx_output_props #(.IDLE_PERIODS(IDLE_PERIODS)) i_props (
	.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .drive_strength_hi(drive_strength_hi),
	.output_pixel_clock(output_pixel_clock),
	.pixel_even_out(pixel_even_out), .data_oe(data_oe),
	.control_out_1_oe(control_out_1_oe),
	.link_activity_detect(link_activity_detect),
	.link_activity_detect_oe(link_activity_detect_oe));

// [sim/panel_sink.sv]
`timescale 1ns/1ps
module panel_sink (
	input wire logic        ref_clk,
	input wire logic        data_oe,
	input wire logic        output_pixel_clock,
	input wire logic [23:0] pixel_even_out,
	output logic     [23:0] pix_r,
	output logic     [15:0] edges_r
);
	logic        clk_last_r = 1'b0;
	logic        clk_q_r = 1'b0;
	logic [23:0] pix_last_r = 24'h0;
	logic        clk_w;
	logic [23:0] pix_w;
	// A floating line shows the inverse of what was last driven
	assign clk_w = data_oe ? output_pixel_clock : ~clk_last_r;
	assign pix_w = data_oe ? pixel_even_out : ~pix_last_r;
	initial edges_r = 16'h0;
	always @(posedge ref_clk) begin
		if (data_oe) begin
			clk_last_r <= output_pixel_clock;
			pix_last_r <= pixel_even_out;
		end
	end
	always @(posedge ref_clk) begin
		clk_q_r <= clk_w;
		if (clk_w && !clk_q_r) begin
			edges_r <= edges_r + 16'h1;
			pix_r <= pix_w;
		end
	end
endmodule

// [sim/tb_rx_output_power_sync_ctrl.sv]
`timescale 1ns/1ps
`include "video_out_cfg.svh"
module tb_rx_output_power_sync_ctrl;
	logic        ref_clk = 0, rst = 1, pclk = 0, hsel = 0, hwrite = 0;
	logic        de_in = 0, de_run = 0, de_kick = 0, opc_q = 0;
	logic        hs = 0, vs = 0, c1 = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, rd, rnd = 32'd76397;
	logic [23:0] pixel_in = 0, ev_q = 0, od_q = 0, xp = 0;
	logic [3:0]  xc = 0;
	wire  [31:0] hrdata;
	wire  [23:0] ev, od, pix_seen;
	wire  [15:0] edges;
	wire         hreadyout, hresp, irq, dsh, opc, de_o, hs_o, vs_o, doe;
	wire         c1_o, c1_oe, lad, lad_oe;
	int          fail_count = 0, n_compared = 0, per = 0, run = 0;
	int          lag = 0, sc = 0, e;
	video_out_ctrl #(.IDLE_PERIODS(40)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.pixel_clk_in(pclk), .de_in(de_in), .hsync_in(hs), .vsync_in(vs),
		.control_out_1_in(c1), .pixel_in(pixel_in), .drive_strength_hi(dsh),
		.output_pixel_clock(opc), .pixel_even_out(ev), .pixel_odd_out(od),
		.de_out(de_o), .hsync_out(hs_o), .vsync_out(vs_o), .data_oe(doe),
		.control_out_1(c1_o), .control_out_1_oe(c1_oe),
		.link_activity_detect(lad), .link_activity_detect_oe(lad_oe));
	panel_sink i_sink (.ref_clk(ref_clk), .data_oe(doe),
		.output_pixel_clock(opc), .pixel_even_out(ev), .pix_r(pix_seen),
		.edges_r(edges));
	always #5 ref_clk = ~ref_clk;
	always #62.5 pclk = ~pclk;
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
	endfunction
	// Link source: data change on the falling pixel clock edge
	always @(negedge pclk) begin
		rnd = nxt(rnd);
		pixel_in <= rnd[23:0];
		{hs, vs, c1} <= rnd[26:24];
		if ((de_run && rnd[27] && rnd[28]) || de_kick) begin
			de_in <= ~de_in;
			de_kick <= 1'b0;
		end
	end
	// Output clock period and even-after-odd lag, in ref cycles
	always @(posedge ref_clk) begin
		opc_q <= opc;
		od_q <= od;
		ev_q <= ev;
		if (opc && !opc_q) begin
			per <= run;
			run <= 1;
		end else
			run <= run + 1;
		sc <= (od !== od_q) ? 1 : sc + 1;
		if (ev !== ev_q)
			lag <= (od !== od_q) ? 0 : sc;
	end
	task results;
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_rng(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task pix(input int n);
		repeat (n) @(posedge pclk);
		@(posedge ref_clk);
	endtask
	task wait_link(input logic v);
		int k;
		for (k = 0; k < 600 && lad !== v; k++)
			@(posedge ref_clk);
		chk(lad, v);
	endtask
	initial begin
		#200000;
		fail_count++;
		results();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		bus(`REG_CTRL, 0, 0); chk(rd, 32'h1c);
		bus(32'h10, 0, 0); chk(rd, 32'h0);
		chk(doe, 1);
		chk(lad, 0);
		de_run = 1;
		wait_link(1);
		chk(irq, 0);
		bus(`REG_IRQ_MASK, 1, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1);
		bus(`REG_IRQ_STATUS, 1, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 0);
		for (int i = 1; i >= 0; i--) begin
			bus(`REG_CTRL, 1, 32'h1c | i);
			repeat (2) @(posedge ref_clk);
			chk(dsh, i);
		end
		// DE held still so that no rising DE realigns the pairs
		de_run = 0;
		bus(`REG_CTRL, 1, 32'h1a); pix(8);
		chk_rng(per, 24, 26);
		chk_rng(lag, 5, 7);
		bus(`REG_CTRL, 1, 32'h1e); pix(8);
		chk_rng(lag, 0, 0);
		de_run = 1;
		bus(`REG_CTRL, 1, 32'h1c); pix(8);
		chk_rng(per, 12, 13);
		chk(od, 0);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			xp = pixel_in;
			xc = {c1, vs, hs, de_in};
			repeat (8) @(posedge ref_clk);
			chk(ev, xp);
			chk({c1_o, vs_o, hs_o, de_o}, xc);
			@(posedge pclk);
			repeat (2) @(posedge ref_clk);
			chk(pix_seen, xp);
		end
		bus(`REG_CTRL, 1, 32'h14); pix(2);
		e = edges; pix(4);
		chk(edges, e);
		chk({doe, c1_oe, lad_oe}, 3'b011);
		bus(`REG_CTRL, 1, 32'h0c); de_run = 0; pix(60);
		chk(lad, 1);
		e = ev;
		pix(4);
		chk(ev, e);
		chk({doe, c1_oe, lad_oe}, 3'b000);
		bus(`REG_CTRL, 1, 32'h1c); pix(25);
		chk(lad, 1);
		de_kick <= 1'b1; pix(25);
		chk(lad, 1);
		wait_link(0);
		bus(`REG_CTRL, 1, 32'h3c);
		repeat (2) @(posedge ref_clk);
		chk(doe, 0);
		de_run = 1;
		wait_link(1);
		repeat (2) @(posedge ref_clk);
		chk(doe, 1);
		bus(`REG_STATE, 0, 0);
		chk_rng(rd, 32'h000c0003, 32'h000d0003);
		bus(`REG_IRQ_STATUS, 0, 0);
		chk(rd, 32'h3);
		results();
	end
endmodule
